// ==== sxd_consts.vh ====
// Constants for the subtract and extended-op decode block
`ifndef SXD_CONSTS_VH
`define SXD_CONSTS_VH
// APB register byte offsets
`define SXD_OFF_CTRL   12'h000
`define SXD_OFF_INSTR  12'h004
`define SXD_OFF_WORK   12'h008
`define SXD_OFF_BANK   12'h00C
`define SXD_OFF_STATUS 12'h010
`define SXD_OFF_FSR0   12'h014
`define SXD_OFF_FSR1   12'h018
`define SXD_OFF_THIRD_POINTER   12'h01C
`define SXD_OFF_FADDR  12'h020
`define SXD_OFF_FDATA  12'h024
`define SXD_OFF_PC     12'h028
`define SXD_OFF_INFO   12'h02C
// Opcode patterns
`define SXD_OP_SUBFILE 6'h17
`define SXD_OP_FSRHI   8'hE8
`define SXD_OP_ADDF    8'hE8
`define SXD_OP_SUBF    8'hE9
`define SXD_OP_PUSHLIT 8'hEA
`define SXD_OP_MOVS    8'hEB
`define SXD_OP_CALLWRK 16'h0014
`define SXD_OP_SECOND  4'hF
// Indexed window limit
`define SXD_IDX_MAX    8'h5F
// Quarter codes
`define SXD_Q1         2'h0
`define SXD_Q2         2'h1
`define SXD_Q3         2'h2
`define SXD_Q4         2'h3
// Reset values
`define SXD_RST_PTR    12'h000
`define SXD_RST_BYTE   8'h00
`define SXD_RST_PC     16'h0000
// Status bit positions
`define SXD_ST_C       0
`define SXD_ST_DC      1
`define SXD_ST_Z       2
`define SXD_ST_OV      3
`define SXD_ST_N       4
`endif

// ==== sxd_decode.v ====
// Subtract-from-file and extended instruction decode and execute core
//
// Contract
// RL1 - 010111da opcode computes file minus working
// RL2 - d=0 writes working, d=1 writes file
// RL3 - a=0 access bank, a=1 bank select
// RL4 - Extended, a=0, f<=95: offset from third pointer
// RL5 - One word, four quarters: decode,read,process,write
// RL6 - Extended ops off unless enable bit set
// RL7 - E8/E9 add/sub 6-bit literal to pointer
// RL8 - Pointer field 11: modify third, then return
// RL9 - Opcode 0014 calls via working register
// RL10 - EB: two-word move from third pointer offset
// RL11 - EA pushes literal, decrements third pointer
// RL12 - Subtract updates N OV C DC Z
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "sxd_consts.vh"
module sxd_decode (
   // Clock and reset
   input  wire        clk,
   input  wire        rst,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr
);
   ////////////////////////////////////////////////////////////////////////////
   reg  [7:0]  ctrl;
   reg  [15:0] instr;
   reg  [15:0] instr2;
   reg         pending;
   reg         busy;
   reg  [1:0]  quarter;
   reg         cycle2;
   reg         retPending;
   reg  [7:0]  working_register;
   reg  [3:0]  bank_select_reg;
   reg  [4:0]  status;
   reg  [11:0] fsr0;
   reg  [11:0] fsr1;
   reg  [11:0] third_pointer;
   reg  [15:0] pc;
   reg  [15:0] retAddr;
   reg  [7:0]  latched;
   reg  [8:0]  result;
   reg  [11:0] fAddrDbg;
   reg         done;
   wire [7:0]  ramRd;
   wire [7:0]  ramRdDbg;
   wire        extEn = ctrl[0];
   wire        apbSetup = psel && !penable;
   wire        apbWr = psel && penable && pwrite && pready;
   // Decode terms
   wire        isSub   = (instr[15:10] == `SXD_OP_SUBFILE);               // RL1
   wire        isAddF  = extEn && (instr[15:8] == `SXD_OP_ADDF);          // RL6 RL7
   wire        isSubF  = extEn && (instr[15:8] == `SXD_OP_SUBF);          // RL6 RL7
   wire        isPush  = extEn && (instr[15:8] == `SXD_OP_PUSHLIT);       // RL6 RL11
   wire        isMovs  = extEn && (instr[15:8] == `SXD_OP_MOVS);          // RL6 RL10
   wire        isCallW = extEn && (instr == `SXD_OP_CALLWRK);             // RL6 RL9
   wire        dBit = instr[9];
   wire        aBit = instr[8];
   wire [1:0]  ptrSel = instr[7:6];
   wire [5:0]  lit6 = instr[5:0];
   ////////////////////////////////////////////////////////////////////////////
   // File address for the subtract instruction
   reg  [11:0] subAddr;
   always @* begin
      if (!aBit && extEn && (instr[7:0] <= `SXD_IDX_MAX)) begin
         subAddr = third_pointer + {4'h0, instr[7:0]};                             // RL4
      end else if (!aBit) begin
         subAddr = {{4{instr[7]}}, instr[7:0]};                          // RL3
      end else begin
         subAddr = {bank_select_reg, instr[7:0]};                                     // RL3
      end
   end
   // Move source and destination
   wire [11:0] movSrc = third_pointer + {5'h00, instr[6:0]};                      // RL10
   wire [11:0] movDst = instr[7] ? (third_pointer + {5'h00, instr2[6:0]})
                                 : instr2[11:0];                          // RL10
   reg  [11:0] rdAddr;
   always @* begin
      rdAddr = isMovs ? movSrc : subAddr;
   end
   // Write port
   reg         ramWe;
   reg  [11:0] ramWa;
   reg  [7:0]  ramWd;
   always @* begin
      ramWe = 1'b0;
      ramWa = subAddr;
      ramWd = result[7:0];
      if (busy && (quarter == `SXD_Q4)) begin
         if (isSub && dBit) begin
            ramWe = 1'b1;                                                 // RL2
         end else if (isPush) begin
            ramWe = 1'b1;                                                 // RL11
            ramWa = third_pointer;
            ramWd = instr[7:0];
         end else if (isMovs && cycle2) begin
            ramWe = 1'b1;                                                 // RL10
            ramWa = movDst;
            ramWd = latched;
         end
      end
   end
   sxd_file_ram uRam (
      .clk    (clk),
      .wrEn   (ramWe),
      .wrAddr (ramWa),
      .wrData (ramWd),
      .rdAddr (rdAddr),
      .rdData (ramRd)
   );
   // Pointer arithmetic
   function [11:0] ptrStep;
      input [11:0] ptr;
      input        sub;
      input [5:0]  k;
      begin
         ptrStep = sub ? (ptr - {6'h00, k}) : (ptr + {6'h00, k});
      end
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   // Execution sequencer, one quarter per clock
   always @(posedge clk) begin
      if (rst) begin
         busy       <= 1'b0;
         quarter    <= `SXD_Q1;
         cycle2     <= 1'b0;
         retPending <= 1'b0;
         working_register       <= `SXD_RST_BYTE;
         status     <= 5'h00;
         fsr0       <= `SXD_RST_PTR;
         fsr1       <= `SXD_RST_PTR;
         third_pointer       <= `SXD_RST_PTR;
         pc         <= `SXD_RST_PC;
         retAddr    <= `SXD_RST_PC;
         latched    <= `SXD_RST_BYTE;
         result     <= 9'h000;
         done       <= 1'b0;
      end else if (!busy) begin
         if (pending) begin
            busy    <= 1'b1;
            quarter <= `SXD_Q1;
            cycle2  <= 1'b0;
            done    <= 1'b0;
         end
      end else begin
         quarter <= quarter + 2'h1;
         case (quarter)
            `SXD_Q1: begin
               result <= result;                                          // RL5
            end
            `SXD_Q2: begin
               latched <= ramRd;                                          // RL5
            end
            `SXD_Q3: begin
               if (isSub) begin
                  result <= {1'b0, latched} - {1'b0, working_register};               // RL1
               end
            end
            default: begin
               if (isSub) begin
                  if (!dBit) begin
                     working_register <= result[7:0];                                 // RL2
                  end
                  status[`SXD_ST_C]  <= ~result[8];                       // RL12
                  status[`SXD_ST_Z]  <= (result[7:0] == 8'h00);           // RL12
                  status[`SXD_ST_N]  <= result[7];                        // RL12
                  status[`SXD_ST_DC] <= (latched[3:0] >= working_register[3:0]);      // RL12
                  status[`SXD_ST_OV] <= (latched[7] != working_register[7]) &&
                                        (result[7] != latched[7]);        // RL12
               end else if (isAddF || isSubF) begin
                  if (!cycle2) begin
                     case (ptrSel)                                        // RL7
                        2'h0: fsr0 <= ptrStep(fsr0, isSubF, lit6);
                        2'h1: fsr1 <= ptrStep(fsr1, isSubF, lit6);
                        default: third_pointer <= ptrStep(third_pointer, isSubF, lit6);     // RL8
                     endcase
                  end else begin
                     pc <= retAddr;                                       // RL8
                  end
               end else if (isPush) begin
                  third_pointer <= third_pointer - 12'h001;                                 // RL11
               end else if (isCallW && !cycle2) begin
                  retAddr <= pc + 16'h0001;                               // RL9
                  pc      <= {8'h00, working_register};                               // RL9
               end
               // Second cycle for returns, calls and moves
               if (!cycle2 && (((isAddF || isSubF) && (ptrSel == 2'h3)) ||
                               isCallW || isMovs)) begin
                  cycle2 <= 1'b1;                                         // RL8 RL9 RL10
               end else begin
                  busy <= 1'b0;
                  done <= 1'b1;
                  if (!isCallW && !((isAddF || isSubF) && ptrSel == 2'h3)) begin
                     pc <= pc + (isMovs ? 16'h0002 : 16'h0001);
                  end
               end
            end
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Register file and APB slave, no wait states
   always @(posedge clk) begin
      if (rst) begin
         ctrl     <= `SXD_RST_BYTE;
         instr    <= 16'h0000;
         instr2   <= 16'hF000;
         bank_select_reg      <= 4'h0;
         pending  <= 1'b0;
         fAddrDbg <= 12'h000;
         prdata   <= 32'h00000000;
         pready   <= 1'b0;
         pslverr  <= 1'b0;
      end else begin
         pready  <= apbSetup;
         pslverr <= 1'b0;
         if (pending && !busy) begin
            pending <= 1'b0;
         end
         if (apbSetup) begin
            case (paddr)
               `SXD_OFF_CTRL:   prdata <= {24'h0, ctrl};
               `SXD_OFF_INSTR:  prdata <= {instr2, instr};
               `SXD_OFF_WORK:   prdata <= {24'h0, working_register};
               `SXD_OFF_BANK:   prdata <= {28'h0, bank_select_reg};
               `SXD_OFF_STATUS: prdata <= {25'h0, busy, pending, status};
               `SXD_OFF_FSR0:   prdata <= {20'h0, fsr0};
               `SXD_OFF_FSR1:   prdata <= {20'h0, fsr1};
               `SXD_OFF_THIRD_POINTER:   prdata <= {20'h0, third_pointer};
               `SXD_OFF_FADDR:  prdata <= {20'h0, fAddrDbg};
               `SXD_OFF_FDATA:  prdata <= {24'h0, ramRdDbg};
               `SXD_OFF_PC:     prdata <= {16'h0, pc};
               `SXD_OFF_INFO:   prdata <= {31'h0, done};
               default: begin
                  prdata  <= 32'h00000000;
                  pslverr <= 1'b1;
               end
            endcase
         end
         if (apbWr) begin
            case (paddr)
               `SXD_OFF_CTRL:  ctrl <= pwdata[7:0];                       // RL6
               `SXD_OFF_INSTR: begin
                  if (!busy) begin
                     instr   <= pwdata[15:0];
                     instr2  <= pwdata[31:16];
                     pending <= 1'b1;
                  end
               end
               `SXD_OFF_BANK:  bank_select_reg <= pwdata[3:0];
               `SXD_OFF_FADDR: fAddrDbg <= pwdata[11:0];
               default: ;
            endcase
         end
      end
   end
   // Debug peek reads the file at a software address
   sxd_file_ram uPeek (
      .clk    (clk),
      .wrEn   (ramWe),
      .wrAddr (ramWa),
      .wrData (ramWd),
      .rdAddr (fAddrDbg),
      .rdData (ramRdDbg)
   );
endmodule // sxd_decode

// ==== sxd_decode_bench.sv ====
// Self-checking bench for the decode block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module sxd_decode_bench;
   logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q, word;
   logic        pready, pslverr, qe;
   logic [3:0]  idx = 4'h0;
   logic [7:0]  litA = 8'h00, litB = 8'h00;
   int          failures = 0, comparisons = 0, cycles = 0, seed = 32'h0056;
   int          mem [256];
   int          w = 0, third_pointer = 0, st = 0, r = 0;
   sxd_decode sxd_decode_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   sxd_fetch_model sxd_fetch_model_i (.idx(idx), .litA(litA), .litB(litB), .word(word));
   initial forever #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_of_test;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
      q = prdata;
      qe = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task automatic peek(input int a);
      apb(1, 12'h020, a);
      apb(0, 12'h024, 0);
   endtask
   // Polls status rather than counting quarters, so slow decode still passes
   task automatic exec(input logic [31:0] ins);
      int n;
      n = 0;
      apb(1, 12'h004, ins);
      repeat (2) @(posedge clk);
      do apb(0, 12'h010, 0); while (q[6:5] !== 2'b00 && ++n < 30);
      `CHK("idle", 2'b00, q[6:5])
   endtask
   function automatic int subf(input int f, input int v);
      int res;
      res = (f - v) & 255;
      st = (res[7] << 4) | ((((f ^ v) & (f ^ res) & 128) != 0) << 3) | ((res == 0) << 2)
         | (((f & 15) >= (v & 15)) << 1) | (f >= v);
      return res;
   endfunction
   task end_of_test;
      $display("checks %0d mismatches %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      litA = $random(seed);
      litB = $random(seed);
      repeat (16) @(posedge clk);
      rst <= 0;
      apb(0, 12'h010, 0); `CHK("status", 32'h0, q)
      apb(0, 12'h000, 0); `CHK("ctrl", 32'h0, q[0])
      apb(1, 12'h000, 1);
      for (int i = 0; i < 10; i++) begin
         if (i == 9) apb(1, 12'h000, 0);
         idx <= i;
         @(posedge clk);
         exec(word);
         case (i)
            0: begin third_pointer = 32; apb(0, 12'h01C, 0); `CHK("third_pointer", third_pointer, q) end
            1, 3: begin
               mem[third_pointer] = (i == 1) ? litA : litB;
               peek(third_pointer); `CHK("push", mem[third_pointer], q[7:0])
               third_pointer--; apb(0, 12'h01C, 0); `CHK("third_pointer", third_pointer, q)
            end
            2: begin
               w = subf(mem[32], w); apb(0, 12'h008, 0); `CHK("working_register", w, q[7:0])
               apb(0, 12'h010, 0); `CHK("flags", st, q[4:0])
            end
            4: begin
               mem[31] = subf(mem[31], w); peek(31); `CHK("file", mem[31], q[7:0])
               apb(0, 12'h010, 0); `CHK("flags", st, q[4:0])
            end
            5: begin
               apb(0, 12'h014, 0); `CHK("fsr0", 32'h015, q)
               apb(0, 12'h010, 0); `CHK("flags", st, q[4:0])
            end
            6: begin apb(0, 12'h018, 0); `CHK("fsr1", 32'hFC1, q) end
            7: begin peek(third_pointer + 3); `CHK("move", mem[31], q[7:0]) end
            8: begin apb(0, 12'h028, 0); `CHK("pc", w, q[7:0]) end
            default: begin apb(0, 12'h01C, 0); `CHK("third_pointer", third_pointer, q) end
         endcase
         $display("test %0d done", i);
      end
      apb(0, 12'h030, 0); `CHK("unmapped", 32'h0, q)
      `CHK("unmapped err", 1'b1, qe)
      $display("test unmapped done");
      end_of_test;
   end
endmodule // sxd_decode_bench

// ==== sxd_decode_properties.sv ====
// Port-level checker for the decode block
`timescale 1ns/10ps
module sxd_checker (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   logic extShadow;
   wire  acc = psel && penable && pready;
   // Tracks the enable bit as software wrote it
   always @(posedge clk) begin
      if (rst) extShadow <= 1'b0;
      else if (acc && pwrite && paddr == 12'h000) extShadow <= pwdata[0];
   end
   a_ready_after_setup: assert property (@(posedge clk) disable iff (rst)
      psel && !penable |=> pready) else $error("no answer after setup");
   a_ready_in_access: assert property (@(posedge clk) disable iff (rst)
      pready |-> psel && penable && $past(psel && !penable)) else $error("stray ready");
   a_ready_one_cycle: assert property (@(posedge clk) disable iff (rst)
      pready |=> !pready) else $error("ready held");
   a_err_with_ready: assert property (@(posedge clk) disable iff (rst)
      pslverr |-> pready) else $error("error without ready");
   a_unmapped_err: assert property (@(posedge clk) disable iff (rst)
      psel && !penable && paddr > 12'h02C |=> pslverr) else $error("unmapped accepted");
   a_mapped_no_err: assert property (@(posedge clk) disable iff (rst)
      psel && !penable && paddr <= 12'h02C && paddr[1:0] == 2'h0 |=> !pslverr)
      else $error("mapped refused");
   a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
      pslverr && !pwrite |-> prdata == 32'h0) else $error("unmapped read not zero");
   a_ext_readback: assert property (@(posedge clk) disable iff (rst)
      acc && !pwrite && paddr == 12'h000 |-> prdata[0] == extShadow) else $error("enable bit");
   a_reset_quiet: assert property (@(posedge clk)
      rst |=> !pready && !pslverr && prdata == 32'h0) else $error("outputs in reset");
endmodule // sxd_checker
bind sxd_decode sxd_checker sxd_checker_i (.clk(clk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ==== sxd_fetch_model.sv ====
// Program memory model handing instruction words to the bench
`timescale 1ns/10ps
module sxd_fetch_model (
   // Request
   input  wire logic [3:0]  idx,
   input  wire logic [7:0]  litA,
   input  wire logic [7:0]  litB,
   // Fetched words, second word in the upper half
   output logic      [31:0] word
);
   always @* begin
      case (idx)
         4'h0: word = 32'h0000E8E0;
         4'h1: word = {24'h0000EA, litA};
         4'h2: word = 32'h00005C01;
         4'h3: word = {24'h0000EA, litB};
         4'h4: word = 32'h00005F1F;
         4'h5: word = 32'h0000E815;
         4'h6: word = 32'h0000E97F;
         4'h7: word = 32'hF003EB81;
         4'h8: word = 32'h00000014;
         default: word = {24'h0000EA, litA};
      endcase
   end
endmodule // sxd_fetch_model

// ==== sxd_file_ram.v ====
// Data memory of file registers, flip-flop storage
`timescale 1ns/10ps
module sxd_file_ram (
   // Clock
   input  wire        clk,
   // Write port
   input  wire        wrEn,
   input  wire [11:0] wrAddr,
   input  wire [7:0]  wrData,
   // Read port
   input  wire [11:0] rdAddr,
   output wire [7:0]  rdData
);
   // Small model: only 256 bytes backed, address folded
   reg  [7:0] mem [0:255];
   genvar     i;
   generate
      for (i = 0; i < 256; i = i + 1) begin : gCell
         always @(posedge clk) begin
            if (wrEn && (wrAddr[7:0] == i[7:0])) begin
               mem[i] <= wrData;
            end
         end
      end
   endgenerate
   assign rdData = mem[rdAddr[7:0]];
endmodule // sxd_file_ram
